// ### dv/smc_top_tb_top.sv
/*
 * Self-checking bench for smc_top: register masks, bank decode, trip levels, status flags.
 * Assumes the bench drives every port; sleep, wake and duty cycling are timed against the 32 kHz tick.
 */
module smc_top_tb_top import smc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, bank_ext, sleep_req, wake_irq;
	logic rdata_valid, chip_reset, monitor_on;
	logic [7:0] rdata, ctrl_out, trim_out;
	smc_io_t io;
	smc_cmp_t cmp_raw;
	int miscompares, check_count;
	smc_top dut (.clk(clk), .rst(rst), .io(io), .bank_ext(bank_ext), .sleep_req(sleep_req),
		.wake_irq(wake_irq), .cmp_raw(cmp_raw), .rdata(rdata), .rdata_valid(rdata_valid),
		.chip_reset(chip_reset), .monitor_on(monitor_on), .ctrl_out(ctrl_out), .trim_out(trim_out));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task end_of_test;
		if (miscompares == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task acc(input logic w, input logic [8:0] a, input logic [7:0] d);
		@(posedge clk);
		io <= '{1'b1, w, !w, a, d};
		@(posedge clk);
		io <= '0;
	endtask
	task rd(input logic [8:0] a, input logic [7:0] e, input string n);
		int i;
		acc(1'b0, a, 8'h00);
		#1;
		for (i = 0; i < 4 && rdata_valid !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 4) begin
			cmp8("rdata_valid", 8'h01, 8'h00);
			end_of_test();
		end
		cmp8(n, e, rdata);
	endtask
	// comparators pass a synchroniser, so allow settling before sampling
	task probe(input logic [7:0] c, input logic [2:0] lv, input logic [3:0] ld, input logic [1:0] s, input logic r);
		acc(1'b1, SMC_CTRL_OFS, c);
		@(posedge clk);
		cmp_raw <= '{lv, ld};
		repeat (8) @(posedge clk);
		rd(SMC_STAT_OFS, {6'h00, s}, "stat");
		cmp8("chip_reset", {7'h00, r}, {7'h00, chip_reset});
	endtask
	task t_regs;
		int d;
		rd(SMC_CTRL_OFS, 8'h00, "ctrl");
		rd(SMC_STAT_OFS, 8'h00, "stat");
		for (d = 0; d < 4; d++) begin
			acc(1'b1, SMC_TRIM_OFS, {d[1:0], 6'h3F});
			rd(SMC_TRIM_OFS, {d[1:0], 6'h00}, "trim");
			cmp8("trim_out", {d[1:0], 6'h00}, trim_out);
		end
		acc(1'b1, SMC_CTRL_OFS, 8'hFF);
		rd(SMC_CTRL_OFS, 8'h37, "ctrl");
		cmp8("ctrl_out", 8'h37, ctrl_out);
		acc(1'b1, SMC_STAT_OFS, 8'hFF);
		rd(SMC_STAT_OFS, 8'h00, "stat");
	endtask
	task t_bank;
		@(posedge clk);
		bank_ext <= 1'b0;
		acc(1'b1, SMC_CTRL_OFS, 8'h00);
		acc(1'b0, SMC_CTRL_OFS, 8'h00);
		#1;
		cmp8("rdata_valid", 8'h00, {7'h00, rdata_valid});
		@(posedge clk);
		bank_ext <= 1'b1;
		rd(SMC_CTRL_OFS, 8'h37, "ctrl");
		acc(1'b0, 9'h1E5, 8'h00);
		#1;
		cmp8("rdata_valid", 8'h00, {7'h00, rdata_valid});
	endtask
	task t_trip;
		int c;
		logic [2:0] h;
		for (c = 0; c < 4; c++) begin
			// level 11 reads the 3 V comparator but must not reset
			h = 3'h1 << ((c == 3) ? 1 : c);
			probe({2'h0, c[1:0], 4'h4}, h, 4'h0, 2'h1, c != 3);
			probe({2'h0, c[1:0], 4'h4}, ~h, 4'h0, 2'h0, 1'b0);
		end
	endtask
	task t_lvd;
		int v;
		logic [3:0] h;
		for (v = 4; v < 8; v++) begin
			h = 4'h1 << (v - 4);
			probe({5'h00, v[2:0]}, 3'h0, h, 2'h2, 1'b0);
			probe({5'h00, v[2:0]}, 3'h0, ~h, 2'h0, 1'b0);
		end
		probe(8'h03, 3'h0, 4'hF, 2'h0, 1'b0);
	endtask
	task cmpn(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %0d seen %0d", n, e, g);
		end
	endtask
	// count cycles while monitor_on holds lvl; a level stuck past the limit ends the run
	task mon_run(input logic lvl, input int lim, output logic [15:0] n);
		n = 16'h0000;
		while (monitor_on === lvl && n < lim) begin
			@(posedge clk);
			#1;
			n = n + 16'h0001;
		end
		if (monitor_on === lvl) begin
			cmp8("monitor_on", {7'h00, !lvl}, {7'h00, monitor_on});
			end_of_test();
		end
	endtask
	// the first on and off phases after sleep entry may be partial, so time the second pair
	task sleep_duty(input logic [1:0] code, input int periods);
		int lim;
		logic [15:0] n;
		lim = periods * SMC_LS_DIV + 8;
		acc(1'b1, SMC_TRIM_OFS, {code, 6'h00});
		@(posedge clk);
		sleep_req <= 1'b1;
		@(posedge clk);
		sleep_req <= 1'b0;
		#1;
		mon_run(1'b1, lim, n);
		mon_run(1'b0, lim, n);
		mon_run(1'b1, lim, n);
		cmpn("on cycles", 16'(SMC_LS_DIV), n);
		mon_run(1'b0, lim, n);
		cmpn("off cycles", 16'((periods - 1) * SMC_LS_DIV), n);
	endtask
	// called early in an off phase: the monitor powers up one tick after wake, samples two ticks later
	task wake(input logic [1:0] pre, input logic [1:0] post);
		logic [15:0] n;
		@(posedge clk);
		wake_irq <= 1'b1;
		@(posedge clk);
		wake_irq <= 1'b0;
		#1;
		mon_run(1'b0, 2 * SMC_LS_DIV + 8, n);
		repeat (2 * SMC_LS_DIV - 8) @(posedge clk);
		rd(SMC_STAT_OFS, {6'h00, pre}, "stat before sample");
		repeat (16) @(posedge clk);
		rd(SMC_STAT_OFS, {6'h00, post}, "stat after sample");
		cmp8("monitor_on", 8'h01, {7'h00, monitor_on});
	endtask
	task t_sleep;
		logic [15:0] n;
		@(posedge clk);
		cmp_raw <= '0;
		// the bench clock is above 12 MHz, so software keeps the 5 V trip level
		acc(1'b1, SMC_CTRL_OFS, 8'h24);
		sleep_duty(2'h2, 32);
		mon_run(1'b1, SMC_LS_DIV + 8, n);
		wake(2'h0, 2'h0);
		sleep_duty(2'h3, 8);
		mon_run(1'b1, SMC_LS_DIV + 8, n);
		@(posedge clk);
		cmp_raw <= '{3'h4, 4'h1};
		repeat (8) @(posedge clk);
		rd(SMC_STAT_OFS, 8'h00, "stat while off");
		cmp8("chip_reset", 8'h00, {7'h00, chip_reset});
		mon_run(1'b0, 8 * SMC_LS_DIV + 8, n);
		mon_run(1'b1, SMC_LS_DIV + 8, n);
		rd(SMC_STAT_OFS, 8'h03, "stat after on");
		cmp8("chip_reset", 8'h01, {7'h00, chip_reset});
		@(posedge clk);
		cmp_raw <= '0;
		wake(2'h3, 2'h0);
		cmp8("chip_reset", 8'h00, {7'h00, chip_reset});
	endtask
	initial begin
		rst = 1'b1;
		bank_ext = 1'b1;
		sleep_req = 1'b0;
		wake_irq = 1'b0;
		io = '0;
		cmp_raw = '0;
		miscompares = 0;
		check_count = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_bank();
		t_trip();
		t_lvd();
		t_sleep();
		end_of_test();
	end
endmodule

// ### src/smc_pkg.sv
/*
 * Package for the supply monitor control block: register offsets, field positions,
 * reset values, duty-cycle codes and timing constants.
 * Assumes a CPU-style I/O port with a bank select flag and 8-bit data.
 */
// Functional notes
// - Bits 5:4 of the control register hold the reset trip level that picks the supply level forcing chip reset.
// - Trip level 00 selects the 2.7 V range, 01 the 3 V range and 10 the 5 V range.
// - Trip level 11 never resets the chip but still reports the comparator against the 3 V range.
// - Status bit 1 reads 1 while the supply is below the threshold set by bits 2:0; codes 000 to 011 are reserved.
// - Status bit 0 reads 1 while the supply is below the trip point chosen by the trip level.
// - The status register is read only, returns the held comparator flags, bits 7:2 read zero, writes are ignored.
// - Bits 7:6 of the trim register set the monitor on/off ratio in 32 kHz periods.
// - Duty code 00 gives 1/128, 01 gives 1/512, 10 gives 1/32 and 11 gives 1/8.
// - The three registers decode only when the extended bank select flag is set.
// - During sleep the monitor runs only duty-cycled, so detection latency grows with the duty setting.
// - On wake the comparators are sampled at the second rising 32 kHz edge after the wake is synchronised.
package smc_pkg;
	localparam logic [8:0] SMC_CTRL_OFS = 9'h1E3;
	localparam logic [8:0] SMC_STAT_OFS = 9'h1E4;
	localparam logic [8:0] SMC_TRIM_OFS = 9'h1EB;
	localparam logic [7:0] SMC_CTRL_RST = 8'h00;
	localparam logic [7:0] SMC_TRIM_RST = 8'h00;
	localparam int SMC_LEV_LSB = 4;
	localparam int SMC_DUTY_LSB = 6;
	localparam int SMC_LVT_LSB = 0;
	localparam int SMC_LVD_BIT = 1;
	localparam int SMC_POR_BIT = 0;
	localparam logic [7:0] SMC_CTRL_WMASK = 8'h37;
	localparam logic [7:0] SMC_TRIM_WMASK = 8'hC0;
	// clock and low-speed oscillator rates
	localparam int SMC_CLK_HZ = 20000000;
	localparam int SMC_LS_HZ = 32000;
	localparam int SMC_LS_DIV = SMC_CLK_HZ / SMC_LS_HZ;
	localparam logic [9:0] SMC_LS_DIV_M1 = 10'(SMC_LS_DIV - 1);
	// duty-cycle frame lengths minus one, in 32 kHz periods
	localparam logic [9:0] SMC_FRAME_128 = 10'h07F;
	localparam logic [9:0] SMC_FRAME_512 = 10'h1FF;
	localparam logic [9:0] SMC_FRAME_32 = 10'h01F;
	localparam logic [9:0] SMC_FRAME_8 = 10'h007;
	typedef enum logic [1:0] {
		SMC_LEV_2V7 = 2'h0,
		SMC_LEV_3V = 2'h1,
		SMC_LEV_5V = 2'h2,
		SMC_LEV_OFF = 2'h3
	} smc_lev_t;
	typedef enum logic [1:0] {
		SMC_W_RUN = 2'h0,
		SMC_W_SLEEP = 2'h1,
		SMC_W_SYNC = 2'h3,
		SMC_W_WAIT = 2'h2
	} smc_wake_t;
	typedef struct packed {
		logic sel;
		logic wr;
		logic rd;
		logic [8:0] addr;
		logic [7:0] wdata;
	} smc_io_t;
	typedef struct packed {
		logic [2:0] lev;
		logic [3:0] low_voltage_flag;
	} smc_cmp_t;
endpackage

// ### src/smc_sync2.sv
/*
 * Two-flop synchroniser for a vector of asynchronous levels.
 * Assumes the inputs are quasi-static compared to clk.
 */
module smc_sync2 import smc_pkg::*; #(
	parameter int W = 7
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
		end
	end
	assign dout = s2_q;
endmodule

// ### src/smc_top.sv
/*
 * Supply monitor control: control, status and duty-trim registers on the CPU I/O port,
 * comparator synchronisation, reset generation, sleep duty cycling and wake sampling.
 * Assumes raw analog comparator outputs, one per trip point, and a 20 MHz clk;
 * the 32 kHz timebase is derived here as an enable pulse.
 */
module smc_top import smc_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input smc_io_t io,
	input wire logic bank_ext,
	input wire logic sleep_req,
	input wire logic wake_irq,
	input smc_cmp_t cmp_raw,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output logic chip_reset,
	output logic monitor_on,
	output logic [7:0] ctrl_out,
	output logic [7:0] trim_out
);
	smc_cmp_t cmp_s;
	smc_sync2 #(.W(7)) u_sync (
		.clk(clk),
		.rst(rst),
		.din(cmp_raw),
		.dout(cmp_s)
	);

	logic [7:0] ctrl_q, ctrl_d, trim_q, trim_d;
	logic [7:0] rdata_q, rdata_d;
	logic rv_q, rv_d;
	logic hit_ctrl, hit_stat, hit_trim;
	logic por_flag, lvd_flag, por_live, lvd_live;
	logic [1:0] lev;
	logic [2:0] lvt;

	assign lev = ctrl_q[SMC_LEV_LSB +: 2];
	assign lvt = ctrl_q[SMC_LVT_LSB +: 3];
	assign hit_ctrl = io.sel && bank_ext && io.addr == SMC_CTRL_OFS;
	assign hit_stat = io.sel && bank_ext && io.addr == SMC_STAT_OFS;
	assign hit_trim = io.sel && bank_ext && io.addr == SMC_TRIM_OFS;

	// comparator selection; level 11 watches the 3 V comparator
	always_comb begin
		unique case (smc_lev_t'(lev))
			SMC_LEV_2V7: por_live = cmp_s.lev[0];
			SMC_LEV_3V: por_live = cmp_s.lev[1];
			SMC_LEV_5V: por_live = cmp_s.lev[2];
			SMC_LEV_OFF: por_live = cmp_s.lev[1];
		endcase
		// reserved threshold codes never flag
		lvd_live = lvt[2] ? cmp_s.low_voltage_flag[lvt[1:0]] : 1'b0;
	end

	// 32 kHz enable from divider
	logic [9:0] div_q, div_d;
	logic ls_tick;
	always_comb begin
		ls_tick = div_q == SMC_LS_DIV_M1;
		div_d = ls_tick ? 10'h000 : div_q + 10'h001;
	end

	// sleep duty cycle: one on period per frame
	// the frame keeps counting while running, so the first on period after sleep entry may be short
	logic [9:0] frm_q, frm_d, frm_len;
	always_comb begin
		unique case (trim_q[SMC_DUTY_LSB +: 2])
			2'h0: frm_len = SMC_FRAME_128;
			2'h1: frm_len = SMC_FRAME_512;
			2'h2: frm_len = SMC_FRAME_32;
			2'h3: frm_len = SMC_FRAME_8;
		endcase
		frm_d = frm_q;
		if (ls_tick)
			frm_d = (frm_q >= frm_len) ? 10'h000 : frm_q + 10'h001;
	end

	// wake sequencing
	// the sync state stands in for the wake synchroniser; one tick there, then two more to the sample point
	smc_wake_t wst_q, wst_d;
	logic [1:0] wcnt_q, wcnt_d;
	logic mon_d, mon_q;
	logic samp;
	always_comb begin
		wst_d = wst_q;
		wcnt_d = wcnt_q;
		samp = 1'b0;
		unique case (wst_q)
			SMC_W_RUN: if (sleep_req) wst_d = SMC_W_SLEEP;
			SMC_W_SLEEP: if (wake_irq) wst_d = SMC_W_SYNC;
			SMC_W_SYNC: if (ls_tick) begin
				wst_d = SMC_W_WAIT;
				wcnt_d = 2'h0;
			end
			SMC_W_WAIT: if (ls_tick) begin
				wcnt_d = wcnt_q + 2'h1;
				if (wcnt_q == 2'h1) begin
					samp = 1'b1;
					wst_d = SMC_W_RUN;
				end
			end
		endcase
		// monitor always on when running; duty-cycled in sleep
		mon_d = (wst_q == SMC_W_RUN) || (wst_q == SMC_W_WAIT) || (frm_q == 10'h000);
	end

	// flags follow live state when the monitor is on outside the wake wait state, or at the wake sample; else hold
	logic pf_q, pf_d, lf_q, lf_d;
	always_comb begin
		pf_d = pf_q;
		lf_d = lf_q;
		if ((mon_q && wst_q != SMC_W_WAIT) || samp) begin
			pf_d = por_live;
			lf_d = lvd_live;
		end
	end
	assign por_flag = pf_q;
	assign lvd_flag = lf_q;

	// register access
	// status reads return the held flags, so they lag the comparators by the sync depth plus the flag register
	always_comb begin
		ctrl_d = ctrl_q;
		trim_d = trim_q;
		rdata_d = rdata_q;
		rv_d = 1'b0;
		if (io.wr && hit_ctrl)
			ctrl_d = io.wdata & SMC_CTRL_WMASK;
		if (io.wr && hit_trim)
			trim_d = io.wdata & SMC_TRIM_WMASK;
		if (io.rd) begin
			rv_d = hit_ctrl || hit_stat || hit_trim;
			if (hit_ctrl)
				rdata_d = ctrl_q;
			else if (hit_stat)
				rdata_d = {6'h00, lvd_flag, por_flag};
			else if (hit_trim)
				rdata_d = trim_q;
			else
				rdata_d = 8'h00;
		end
	end

	// registered so chip_reset leaves a flop, at the cost of one cycle of reset latency
	logic rst_d, rst_q;
	assign rst_d = por_flag && lev != SMC_LEV_OFF;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= SMC_CTRL_RST;
			trim_q <= SMC_TRIM_RST;
			rdata_q <= 8'h00;
			rv_q <= 1'b0;
			div_q <= 10'h000;
			frm_q <= 10'h000;
			wst_q <= SMC_W_RUN;
			wcnt_q <= 2'h0;
			mon_q <= 1'b1;
			pf_q <= 1'b0;
			lf_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			trim_q <= trim_d;
			rdata_q <= rdata_d;
			rv_q <= rv_d;
			div_q <= div_d;
			frm_q <= frm_d;
			wst_q <= wst_d;
			wcnt_q <= wcnt_d;
			mon_q <= mon_d;
			pf_q <= pf_d;
			lf_q <= lf_d;
			rst_q <= rst_d;
		end
	end

	assign rdata = rdata_q;
	assign rdata_valid = rv_q;
	assign chip_reset = rst_q;
	assign monitor_on = mon_q;
	assign ctrl_out = ctrl_q;
	assign trim_out = trim_q;

	// checks
	a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
		rv_q && $past(hit_stat) |-> rdata_q[7:2] == 6'h00) else $error("status reserved bits nonzero");
	a_no_reset_off: assert property (@(posedge clk) disable iff (rst)
		$past(lev) == SMC_LEV_OFF |-> !chip_reset) else $error("reset under level 11");
	a_bank_gate: assert property (@(posedge clk) disable iff (rst)
		io.wr && !bank_ext |=> $stable(ctrl_q) && $stable(trim_q)) else $error("write without bank select");
	a_ctrl_mask: assert property (@(posedge clk) disable iff (rst)
		(ctrl_q & ~SMC_CTRL_WMASK) == 8'h00) else $error("control reserved bits set");
	a_trim_mask: assert property (@(posedge clk) disable iff (rst)
		(trim_q & ~SMC_TRIM_WMASK) == 8'h00) else $error("trim reserved bits set");
	a_run_on: assert property (@(posedge clk) disable iff (rst)
		wst_q == SMC_W_RUN ##1 wst_q == SMC_W_RUN |-> monitor_on) else $error("monitor off while running");
	a_reset_follow: assert property (@(posedge clk) disable iff (rst)
		por_flag && lev != SMC_LEV_OFF |=> chip_reset) else $error("reset not raised");
	a_wake_sample: assert property (@(posedge clk) disable iff (rst)
		samp |=> wst_q == SMC_W_RUN && pf_q == $past(por_live)) else $error("wake sample missed");

	// duty-cycle, wake, synchroniser and level 11 status checks
	a_flag_hold: assert property (@(posedge clk) disable iff (rst)
		!mon_q && wst_q == SMC_W_SLEEP |=> $stable(pf_q) && $stable(lf_q)) else $error("flag moved while monitor off");
	a_wait_hold: assert property (@(posedge clk) disable iff (rst)
		wst_q == SMC_W_WAIT && !samp |=> $stable(pf_q) && $stable(lf_q)) else $error("flag moved before wake sample");
	a_wait_on: assert property (@(posedge clk) disable iff (rst)
		wst_q == SMC_W_WAIT ##1 wst_q == SMC_W_WAIT |-> monitor_on) else $error("monitor off while settling");
	a_sync_depth: assert property (@(posedge clk) disable iff (rst)
		!$past(rst) && !$past(rst, 2) |-> cmp_s == $past(cmp_raw, 2)) else $error("comparator sync depth wrong");
	a_off_live: assert property (@(posedge clk) disable iff (rst)
		lev == SMC_LEV_OFF && mon_q && wst_q == SMC_W_RUN |=> pf_q == $past(cmp_s.lev[1]))
		else $error("level 11 status wrong");

	c_wake: cover property (@(posedge clk) samp);
	c_reset: cover property (@(posedge clk) chip_reset);
	c_lvd: cover property (@(posedge clk) lvd_flag);
	c_duty_off: cover property (@(posedge clk) wst_q == SMC_W_SLEEP && !monitor_on);
	c_off_level: cover property (@(posedge clk) lev == SMC_LEV_OFF && por_flag);
endmodule
